// [common/lep_pkg.sv]
package lep_pkg;
  // ****************************************
  // Frame identifiers and layout
  // ****************************************
  localparam logic [10:0] ID_NMT = 11'h000;
  localparam logic [10:0] ID_EMCY_BASE = 11'h080;
  localparam logic [10:0] ID_TPDO_BASE = 11'h180;
  localparam logic [10:0] ID_SDO_TX_BASE = 11'h580;
  localparam logic [10:0] ID_SDO_RX_BASE = 11'h600;
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_ALL = 8'h00;
  localparam logic [7:0] SDO_DL_4 = 8'h22;
  localparam logic [7:0] SDO_DL_ACK = 8'h60;
  localparam logic [7:0] SDO_ABORT = 8'h80;
  localparam logic [15:0] IDX_CYCLE = 16'h6200;
  localparam logic [15:0] IDX_SAVE = 16'h1010;
  localparam logic [15:0] IDX_RESOL = 16'h6005;
  localparam logic [15:0] IDX_PDO_MAP = 16'h1a00;
  localparam logic [7:0] SUB_SAVE = 8'h01;
  localparam logic [31:0] SAVE_SIG = 32'h65766173;
  localparam logic [3:0] DLC_PDO = 4'h6;
  localparam logic [3:0] DLC_FULL = 4'h8;
  // J1939 identifiers
  localparam logic [7:0] J_PRIO = 8'h18;
  localparam logic [7:0] J_PF_DATA = 8'hff;
  localparam logic [15:0] J_CFG_PGN = 16'h18b2;
  localparam logic [23:0] J_CFG_KEY = 24'h53544d;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_HW = 16'h5000;
  localparam logic [15:0] ERR_DATA = 16'h6300;
  localparam logic [15:0] POS_FAULT = 16'hffff;
  localparam logic [7:0] FILL = 8'hff;
  localparam logic [31:0] RES_POS_UM = 32'h00000064;
  localparam logic [31:0] RES_SPD_UM_S = 32'h000003e8;
  localparam logic [15:0] CYCLE_DEF = 16'h000a;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = CLK_MHZ * MS_US;
  localparam int SAVE_MAX_MS = 600;
endpackage : lep_pkg

// [rtl/lep_buf2.sv]
`timescale 1ns/100ps
// Two-entry skid buffer carrying complete frames
module lep_buf2 #(
  parameter int W = 8
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room available
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Receiver takes
  output logic [W-1:0] out_data // Word out
);
  logic [W-1:0] mem [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Handshake terms
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : lep_buf2

// [rtl/lep_encoder_can.sv]
`timescale 1ns/100ps
module lep_encoder_can #(
  parameter int SAVE_MS = lep_pkg::SAVE_MAX_MS, // Save answer bound
  parameter int MS_CYC = lep_pkg::MS_CYCLES // Cycles per millisecond
) (
  input wire logic REF_CLK, // System clock
  input wire logic SYS_RST, // Async reset, high
  input wire logic J1939_MODE, // Variant select
  input wire logic [6:0] NODE_ID, // CANopen node id
  input wire logic NODE_ID_SET, // Node id programmed pulse
  input wire logic [7:0] J_SA, // Wanted J1939 source address
  input wire logic ADDR_CLAIMED, // Address claim won
  input wire logic [15:0] NV_CYCLE, // Stored cycle time
  input wire logic NV_SYNC, // Stored SYNC mode
  input wire logic [7:0] NV_PS, // Stored PDU specific
  output logic NV_SAVE, // Persist request pulse
  output logic [15:0] NV_SAVE_CYCLE, // Value to persist
  input wire logic NV_DONE, // Persist finished pulse
  input wire logic [31:0] POSITION, // Position counts
  input wire logic [15:0] SPEED, // Speed counts
  input wire logic POS_VALID, // New sample pulse
  input wire logic MAG_FAULT, // Magnet missing or in zone
  input wire logic ELEM_FAULT, // Sensing element failed
  input wire logic HW_FAULT, // Hardware error
  input wire logic DATA_FAULT, // Data set error
  input wire logic [7:0] STATUS_IN, // J1939 status byte
  input wire logic [7:0] LIMIT_IN, // J1939 limit status
  input wire logic SYNC_RX, // SYNC received pulse
  input wire logic RX_VALID, // Received frame pulse
  input wire logic RX_EXT, // Received id extended
  input wire logic [28:0] RX_ID, // Received identifier
  input wire logic [63:0] RX_DATA, // Received bytes, byte 0 low
  output logic TX_VALID, // Frame offered
  input wire logic TX_READY, // Controller takes frame
  output logic TX_EXT, // Offered id extended
  output logic [28:0] TX_ID, // Offered identifier
  output logic [3:0] TX_DLC, // Offered length
  output logic [63:0] TX_DATA, // Offered bytes, byte 0 low
  output logic OPERATIONAL, // Sending process data
  output logic [15:0] CYCLE_MS, // Active cycle time
  output logic [7:0] J_PS // Active PDU specific
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int FW = 1 + 29 + 4 + 64;
  localparam int SAVE_CYC = SAVE_MS * MS_CYC;
  typedef enum {ST_LOAD, ST_PREOP, ST_OPER} lep_state_t;
  lep_state_t state;
  logic sync_mode;
  logic [10:0] emcy_id;
  logic [10:0] pdo_id;
  logic [10:0] sdo_tx_id;
  logic [10:0] sdo_rx_id;
  logic [16:0] ms_cnt;
  logic [15:0] ms_left;
  logic [31:0] save_cnt;
  logic save_busy;
  logic cyc_due;
  logic pdo_due;
  logic emcy_due;
  logic sdo_due;
  logic [63:0] sdo_resp;
  logic [15:0] err_code;
  logic [15:0] err_last;
  logic fault;
  logic j_ok;
  logic [7:0] j_sa;
  logic b_in_valid;
  logic b_in_ready;
  logic [FW-1:0] b_in;
  logic b_out_valid;
  logic [FW-1:0] b_out;
  logic [FW-1:0] tx_q;
  logic tx_v;
  logic [7:0] rx_b [8];
  logic is_nmt;
  logic nmt_me;
  logic is_sdo;
  logic is_jcfg;

  // Receive byte split, byte 0 in low bits
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rx_b[i] = RX_DATA[8*i +: 8];
    end
  end

  // Frame classification
  assign is_nmt = RX_VALID && !RX_EXT && RX_ID[10:0] == lep_pkg::ID_NMT && !J1939_MODE;
  assign nmt_me = rx_b[1] == lep_pkg::NMT_ALL || rx_b[1] == {1'b0, NODE_ID};
  assign is_sdo = RX_VALID && !RX_EXT && RX_ID[10:0] == sdo_rx_id && !J1939_MODE;
  assign is_jcfg = RX_VALID && RX_EXT && J1939_MODE && j_ok
    && RX_ID[28:16] == lep_pkg::J_CFG_PGN[12:0] && RX_ID[15:8] == j_sa
    && RX_DATA[23:0] == lep_pkg::J_CFG_KEY && rx_b[3] == 8'h00;

  // Error code selection, hardware fault first
  assign err_code = HW_FAULT ? lep_pkg::ERR_HW : (DATA_FAULT ? lep_pkg::ERR_DATA : lep_pkg::ERR_NONE);
  assign fault = MAG_FAULT || ELEM_FAULT;
  // ****************************************
  // Parameters and identifiers
  // ****************************************
  // Stored values loaded after reset, then SDO or J1939 writes
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CYCLE_MS <= lep_pkg::CYCLE_DEF;
      sync_mode <= 1'b0;
      J_PS <= 8'h00;
    end else if (state == ST_LOAD) begin
      CYCLE_MS <= NV_CYCLE;
      sync_mode <= NV_SYNC;
      J_PS <= NV_PS;
    end else if (is_sdo && rx_b[0] == lep_pkg::SDO_DL_4 && {rx_b[2], rx_b[1]} == lep_pkg::IDX_CYCLE
                 && rx_b[3] == 8'h00 && {rx_b[5], rx_b[4]} != 16'h0000 && !sdo_due && !save_busy) begin
      CYCLE_MS <= {rx_b[5], rx_b[4]};
    end else if (is_jcfg && {rx_b[5], rx_b[4]} != 16'h0000) begin
      CYCLE_MS <= {rx_b[5], rx_b[4]};
    end
  end

  // Identifiers regenerated whenever node id is programmed
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      emcy_id <= lep_pkg::ID_EMCY_BASE;
      pdo_id <= lep_pkg::ID_TPDO_BASE;
      sdo_tx_id <= lep_pkg::ID_SDO_TX_BASE;
      sdo_rx_id <= lep_pkg::ID_SDO_RX_BASE;
    end else if (state == ST_LOAD || NODE_ID_SET) begin
      emcy_id <= lep_pkg::ID_EMCY_BASE + {4'h0, NODE_ID};
      pdo_id <= lep_pkg::ID_TPDO_BASE + {4'h0, NODE_ID};
      sdo_tx_id <= lep_pkg::ID_SDO_TX_BASE + {4'h0, NODE_ID};
      sdo_rx_id <= lep_pkg::ID_SDO_RX_BASE + {4'h0, NODE_ID};
    end
  end

  // ****************************************
  // Network state
  // ****************************************
  // Load, pre-operational and operational states
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD: state <= ST_PREOP;
        ST_PREOP: begin
          if (is_nmt && nmt_me && rx_b[0] == lep_pkg::NMT_START) begin
            state <= ST_OPER;
          end
        end
        ST_OPER: begin
          if (is_nmt && nmt_me && rx_b[0] == lep_pkg::NMT_PREOP) begin
            state <= ST_PREOP;
          end
        end
        default: state <= ST_LOAD;
      endcase
    end
  end

  // J1939 address claim, data only once claimed
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      j_ok <= 1'b0;
      j_sa <= 8'h00;
    end else if (ADDR_CLAIMED && !j_ok) begin
      j_ok <= 1'b1;
      j_sa <= J_SA;
    end
  end

  // Operational flag
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OPERATIONAL <= 1'b0;
    end else begin
      OPERATIONAL <= J1939_MODE ? j_ok : (state == ST_OPER);
    end
  end

  // ****************************************
  // Cycle timer and triggers
  // ****************************************
  // Millisecond prescaler and event timer
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ms_cnt <= 17'h00000;
      ms_left <= 16'h0001;
      cyc_due <= 1'b0;
    end else begin
      cyc_due <= 1'b0;
      if (ms_cnt == 17'(MS_CYC - 1)) begin
        ms_cnt <= 17'h00000;
        if (ms_left <= 16'h0001) begin
          ms_left <= CYCLE_MS;
          cyc_due <= 1'b1;
        end else begin
          ms_left <= ms_left - 16'h0001;
        end
      end else begin
        ms_cnt <= ms_cnt + 17'h00001;
        if (ms_left > CYCLE_MS) begin
          ms_left <= CYCLE_MS;
        end
      end
    end
  end

  // Pending process data, set wins over clear
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pdo_due <= 1'b0;
    end else if ((J1939_MODE ? j_ok : state == ST_OPER)
                 && (sync_mode && !J1939_MODE ? SYNC_RX : cyc_due)) begin
      pdo_due <= 1'b1;
    end else if (!OPERATIONAL || (b_in_valid && b_in_ready && !emcy_due && !sdo_due)) begin
      pdo_due <= 1'b0;
    end
  end

  // Emergency on every error code change, CANopen mode only
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      err_last <= lep_pkg::ERR_NONE;
      emcy_due <= 1'b0;
    end else begin
      if (!J1939_MODE && state != ST_LOAD && err_code != err_last) begin
        err_last <= err_code;
        emcy_due <= 1'b1;
      end else if (b_in_valid && b_in_ready) begin
        emcy_due <= 1'b0;
      end
    end
  end

  // ****************************************
  // SDO server and save
  // ****************************************
  // Build answers, save waits for the store
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sdo_due <= 1'b0;
      sdo_resp <= 64'h0;
      save_busy <= 1'b0;
      save_cnt <= 32'h0;
      NV_SAVE <= 1'b0;
      NV_SAVE_CYCLE <= 16'h0000;
    end else begin
      NV_SAVE <= 1'b0;
      if (save_busy) begin
        save_cnt <= save_cnt + 32'h1;
        if (NV_DONE || save_cnt == 32'(SAVE_CYC - 2)) begin
          save_busy <= 1'b0;
          sdo_due <= 1'b1;
          sdo_resp <= {32'h0, lep_pkg::SUB_SAVE, lep_pkg::IDX_SAVE, lep_pkg::SDO_DL_ACK};
        end
      end else if (is_sdo && !sdo_due) begin
        if (rx_b[0] == lep_pkg::SDO_DL_4 && {rx_b[2], rx_b[1]} == lep_pkg::IDX_CYCLE
            && rx_b[3] == 8'h00 && {rx_b[5], rx_b[4]} != 16'h0000) begin
          sdo_due <= 1'b1;
          sdo_resp <= {40'h0, rx_b[2], rx_b[1], lep_pkg::SDO_DL_ACK};
        end else if (rx_b[0] == lep_pkg::SDO_DL_4 && {rx_b[2], rx_b[1]} == lep_pkg::IDX_SAVE
                     && rx_b[3] == lep_pkg::SUB_SAVE && RX_DATA[63:32] == lep_pkg::SAVE_SIG) begin
          save_busy <= 1'b1;
          save_cnt <= 32'h0;
          NV_SAVE <= 1'b1;
          NV_SAVE_CYCLE <= CYCLE_MS;
        end else if ({rx_b[2], rx_b[1]} == lep_pkg::IDX_RESOL && rx_b[0][7:5] == 3'h2) begin
          sdo_due <= 1'b1;
          sdo_resp <= {(rx_b[3] == 8'h01 ? lep_pkg::RES_POS_UM : lep_pkg::RES_SPD_UM_S),
                       rx_b[3], rx_b[2], rx_b[1], 8'h43};
        end else begin
          sdo_due <= 1'b1;
          sdo_resp <= {32'h0, rx_b[3], rx_b[2], rx_b[1], lep_pkg::SDO_ABORT};
        end
      end else if (sdo_due && b_in_valid && b_in_ready && !emcy_due) begin
        sdo_due <= 1'b0;
      end
    end
  end

  // ****************************************
  // Frame assembly
  // ****************************************
  // Priority: emergency, SDO answer, process data
  always_comb begin
    b_in_valid = emcy_due || sdo_due || pdo_due;
    b_in = '0;
    if (emcy_due) begin
      b_in = {1'b0, 18'h0, emcy_id, lep_pkg::DLC_FULL,
              40'h0, 8'(err_last != lep_pkg::ERR_NONE), err_last[15:8], err_last[7:0]};
    end else if (sdo_due) begin
      b_in = {1'b0, 18'h0, sdo_tx_id, lep_pkg::DLC_FULL, sdo_resp};
    end else if (J1939_MODE) begin
      b_in = {1'b1, lep_pkg::J_PRIO[4:0], lep_pkg::J_PF_DATA, J_PS, j_sa, lep_pkg::DLC_FULL,
              lep_pkg::FILL, LIMIT_IN, err_code[7:0], STATUS_IN,
              SPEED[15:8], SPEED[7:0],
              fault ? lep_pkg::POS_FAULT : POSITION[15:0]};
    end else begin
      b_in = {1'b0, 18'h0, pdo_id, lep_pkg::DLC_PDO, 16'h0, SPEED[15:8], SPEED[7:0],
              fault ? {16'h0, lep_pkg::POS_FAULT} : POSITION};
    end
  end

  lep_buf2 #(.W(FW)) u_buf (
    .clk(REF_CLK), .rst(SYS_RST), .in_valid(b_in_valid), .in_ready(b_in_ready), .in_data(b_in),
    .out_valid(b_out_valid), .out_ready(!tx_v || TX_READY), .out_data(b_out)
  );
  // Registered transmit stage
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_v <= 1'b0;
      tx_q <= '0;
    end else if (!tx_v || TX_READY) begin
      tx_v <= b_out_valid;
      tx_q <= b_out;
    end
  end
  assign TX_VALID = tx_v;
  assign {TX_EXT, TX_ID, TX_DLC, TX_DATA} = tx_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_start;
    is_nmt && nmt_me && rx_b[0] == lep_pkg::NMT_START && state == ST_PREOP;
  endsequence
  chk_nmt_start: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_start |=> state == ST_OPER) else $error("start not taken");
  chk_nmt_stop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    is_nmt && nmt_me && rx_b[0] == lep_pkg::NMT_PREOP |=> state != ST_OPER) else $error("stop not taken");
  chk_emcy_raise: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !J1939_MODE && state != ST_LOAD && err_code != err_last |=> emcy_due) else $error("emergency missed");
  chk_pdo_dlc: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_VALID && TX_ID[10:0] == pdo_id && !TX_EXT |-> TX_DLC == lep_pkg::DLC_PDO) else $error("pdo dlc");
  chk_j_fill: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_VALID && TX_EXT |-> TX_DATA[63:56] == lep_pkg::FILL && TX_DLC == lep_pkg::DLC_FULL) else $error("j fill");
  chk_j_claim: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    J1939_MODE && !j_ok |-> !pdo_due) else $error("data before claim");
  chk_save_bound: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    save_busy |-> save_cnt < 32'(SAVE_CYC)) else $error("save too slow");
  chk_cycle_nonzero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state != ST_LOAD && $changed(CYCLE_MS) |-> CYCLE_MS != 16'h0000) else $error("zero cycle");
endmodule : lep_encoder_can

// [test/encoder_can_process_data_bench.sv]
`timescale 1ns/100ps
module encoder_can_process_data_bench;
  localparam int MSC = 10;
  localparam int SVM = 2;
  logic clk, rst, jmode, node_set, claimed, nv_sync, nv_save, nv_done, mag, elem, hw, dat, sync;
  logic rxv, rxe, txv, txr, txe, oper, stall, slow, got;
  logic [6:0] node;
  logic [7:0] jsa, nv_ps, stat, lim, jps;
  logic [15:0] nv_cyc, nv_save_cyc, spd, cyc;
  logic [31:0] pos;
  logic [28:0] rxid, txid;
  logic [63:0] rxd, txd;
  logic [3:0] txdlc;
  logic [97:0] gf;
  logic [97:0] q[$];
  int mismatches = 0;
  int compares = 0;
  // ****************************************
  // Clock, design and master
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  lep_encoder_can #(.SAVE_MS(SVM), .MS_CYC(MSC)) DUT (.REF_CLK(clk), .SYS_RST(rst), .J1939_MODE(jmode),
    .NODE_ID(node), .NODE_ID_SET(node_set), .J_SA(jsa), .ADDR_CLAIMED(claimed), .NV_CYCLE(nv_cyc),
    .NV_SYNC(nv_sync), .NV_PS(nv_ps), .NV_SAVE(nv_save), .NV_SAVE_CYCLE(nv_save_cyc), .NV_DONE(nv_done),
    .POSITION(pos), .SPEED(spd), .POS_VALID(1'b0), .MAG_FAULT(mag), .ELEM_FAULT(elem), .HW_FAULT(hw),
    .DATA_FAULT(dat), .STATUS_IN(stat), .LIMIT_IN(lim), .SYNC_RX(sync), .RX_VALID(rxv), .RX_EXT(rxe),
    .RX_ID(rxid), .RX_DATA(rxd), .TX_VALID(txv), .TX_READY(txr), .TX_EXT(txe), .TX_ID(txid),
    .TX_DLC(txdlc), .TX_DATA(txd), .OPERATIONAL(oper), .CYCLE_MS(cyc), .J_PS(jps));
  lep_can_master master (.clk(clk), .rst(rst), .stall(stall), .slow(slow), .tx_valid(txv), .tx_ready(txr),
    .tx_ext(txe), .tx_id(txid), .tx_dlc(txdlc), .tx_data(txd), .got(got), .got_frame(gf));
  // Collect every frame the master took
  always @(posedge clk) begin
    if (got === 1'b1) q.push_back(gf);
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [28:0] cid(input logic [10:0] b);
    return {18'h0, b + {4'h0, node}};
  endfunction : cid
  // Wait for a frame with this identifier, dropping others
  task automatic wait_frm(input logic e, input logic [28:0] id, input int n, output logic [3:0] dl,
                          output logic [63:0] d);
    logic [97:0] f;
    dl = 'x;
    d = 'x;
    repeat (n) begin
      @(posedge clk);
      while (q.size() > 0) begin
        f = q.pop_front();
        if (f[97] === e && f[96:68] === id) begin
          dl = f[67:64];
          d = f[63:0];
          return;
        end
      end
    end
    chk("frame arrival", {35'h0, id}, '1);
  endtask : wait_frm
  // Count frames with this identifier (or any) over n cycles
  task automatic quiet(input string nm, input int n, input logic any, input logic [28:0] id);
    int k;
    k = 0;
    repeat (n) @(posedge clk);
    foreach (q[i]) k += (any || q[i][96:68] === id) ? 1 : 0;
    q.delete();
    chk(nm, 64'h0, k);
  endtask : quiet
  task automatic send(input logic e, input logic [28:0] id, input logic [63:0] d);
    @(posedge clk);
    rxv <= 1'b1;
    rxe <= e;
    rxid <= id;
    rxd <= d;
    @(posedge clk);
    rxv <= 1'b0;
  endtask : send
  task automatic do_reset(input logic j, input logic s, input logic [15:0] c);
    @(posedge clk);
    rst <= 1'b1;
    jmode <= j;
    nv_sync <= s;
    nv_cyc <= c;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    q.delete();
  endtask : do_reset
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_start();
    logic [3:0] dl;
    logic [63:0] d;
    do_reset(1'b0, 1'b0, 16'h0003);
    chk("loaded cycle", 16'h0003, cyc);
    chk("idle before start", 1'b0, oper);
    node <= 7'h05;
    node_set <= 1'b1;
    @(posedge clk);
    node_set <= 1'b0;
    send(1'b0, 29'h0, {48'h0, lep_pkg::NMT_ALL, lep_pkg::NMT_START});
    repeat (3) @(posedge clk);
    chk("operational", 1'b1, oper);
    wait_frm(1'b0, cid(lep_pkg::ID_TPDO_BASE), 80, dl, d);
    chk("pdo length", lep_pkg::DLC_PDO, dl);
    chk("pdo data", {spd, pos}, d[47:0]);
    for (int i = 0; i < 2; i++) begin
      mag <= (i == 0);
      elem <= (i == 1);
      wait_frm(1'b0, cid(lep_pkg::ID_TPDO_BASE), 80, dl, d);
      wait_frm(1'b0, cid(lep_pkg::ID_TPDO_BASE), 80, dl, d);
      chk("fault position", lep_pkg::POS_FAULT, d[15:0]);
    end
    mag <= 1'b0;
    elem <= 1'b0;
    $display("test done: start");
  endtask : t_start
  task automatic t_sdo();
    logic [15:0] v[4] = '{16'h0001, 16'hffff, 16'h0000, 16'h0003};
    logic [15:0] x[4] = '{16'h0001, 16'hffff, 16'hffff, 16'h0003};
    logic [3:0] dl;
    logic [63:0] a;
    for (int i = 0; i < 4; i++) begin
      send(1'b0, cid(lep_pkg::ID_SDO_RX_BASE), {16'h0, v[i], 8'h00, lep_pkg::IDX_CYCLE, lep_pkg::SDO_DL_4});
      wait_frm(1'b0, cid(lep_pkg::ID_SDO_TX_BASE), 40, dl, a);
      chk("cycle answer", {8'h00, lep_pkg::IDX_CYCLE, (v[i] != 16'h0) ? lep_pkg::SDO_DL_ACK : lep_pkg::SDO_ABORT},
          a[31:0]);
      repeat (6) @(posedge clk);
      chk("cycle time", x[i], cyc);
    end
    send(1'b0, cid(lep_pkg::ID_SDO_RX_BASE), {32'h0, 8'h01, lep_pkg::IDX_PDO_MAP, lep_pkg::SDO_DL_4});
    wait_frm(1'b0, cid(lep_pkg::ID_SDO_TX_BASE), 40, dl, a);
    chk("remap refused", lep_pkg::SDO_ABORT, a[7:0]);
    send(1'b0, cid(lep_pkg::ID_SDO_RX_BASE), {32'h0, 8'h01, lep_pkg::IDX_RESOL, 8'h40});
    wait_frm(1'b0, cid(lep_pkg::ID_SDO_TX_BASE), 40, dl, a);
    chk("position resolution", lep_pkg::RES_POS_UM, a[63:32]);
    $display("test done: sdo");
  endtask : t_sdo
  task automatic t_save();
    logic [3:0] dl;
    logic [63:0] a;
    int n;
    for (int k = 0; k < 2; k++) begin
      send(1'b0, cid(lep_pkg::ID_SDO_RX_BASE), {lep_pkg::SAVE_SIG, lep_pkg::SUB_SAVE, lep_pkg::IDX_SAVE,
        lep_pkg::SDO_DL_4});
      n = 0;
      while (nv_save !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      chk("persist request", 1'b1, nv_save);
      chk("persisted cycle", 16'h0003, nv_save_cyc);
      if (k == 0) begin
        repeat (4) @(posedge clk);
        nv_done <= 1'b1;
        @(posedge clk);
        nv_done <= 1'b0;
      end
      wait_frm(1'b0, cid(lep_pkg::ID_SDO_TX_BASE), SVM * MSC + 10, dl, a);
      chk("save answer", {lep_pkg::SUB_SAVE, lep_pkg::IDX_SAVE, lep_pkg::SDO_DL_ACK}, a[31:0]);
    end
    $display("test done: save");
  endtask : t_save
  task automatic t_emcy();
    logic [15:0] c[4] = '{lep_pkg::ERR_HW, lep_pkg::ERR_NONE, lep_pkg::ERR_DATA, lep_pkg::ERR_NONE};
    logic [3:0] dl;
    logic [63:0] d;
    for (int i = 0; i < 4; i++) begin
      stall <= (i == 0);
      hw <= (i == 0);
      dat <= (i == 2);
      repeat (30) @(posedge clk);
      stall <= 1'b0;
      slow <= (i == 1);
      wait_frm(1'b0, cid(lep_pkg::ID_EMCY_BASE), 80, dl, d);
      chk("emergency length", lep_pkg::DLC_FULL, dl);
      chk("emergency code", {(c[i] != 16'h0) ? 8'h01 : 8'h00, c[i]}, d[23:0]);
    end
    slow <= 1'b0;
    $display("test done: emergency");
  endtask : t_emcy
  task automatic t_stop();
    send(1'b0, 29'h0, {48'h0, lep_pkg::NMT_ALL, lep_pkg::NMT_PREOP});
    repeat (10) @(posedge clk);
    chk("preoperational", 1'b0, oper);
    q.delete();
    quiet("pdo after stop", 100, 1'b0, cid(lep_pkg::ID_TPDO_BASE));
    $display("test done: stop");
  endtask : t_stop
  task automatic t_sync();
    logic [3:0] dl;
    logic [63:0] d;
    do_reset(1'b0, 1'b1, 16'h0002);
    send(1'b0, 29'h0, {48'h0, lep_pkg::NMT_ALL, lep_pkg::NMT_START});
    quiet("pdo without sync", 100, 1'b0, cid(lep_pkg::ID_TPDO_BASE));
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    wait_frm(1'b0, cid(lep_pkg::ID_TPDO_BASE), 30, dl, d);
    chk("sync pdo data", {spd, pos}, d[47:0]);
    $display("test done: sync");
  endtask : t_sync
  task automatic t_j1939();
    logic [3:0] dl;
    logic [63:0] d;
    logic [28:0] rid;
    rid = {lep_pkg::J_PRIO[4:0], lep_pkg::J_PF_DATA, 8'h20, 8'h42};
    do_reset(1'b1, 1'b0, 16'h0002);
    send(1'b1, {lep_pkg::J_CFG_PGN[12:0], 8'h42, 8'h11}, {32'h5, 8'h00, lep_pkg::J_CFG_KEY});
    quiet("frames before claim", 60, 1'b1, 29'h0);
    chk("config before claim", 16'h0002, cyc);
    claimed <= 1'b1;
    wait_frm(1'b1, rid, 60, dl, d);
    chk("record length", lep_pkg::DLC_FULL, dl);
    chk("record data", {lep_pkg::FILL, lim, 8'h00, stat, spd, pos[15:0]}, d);
    chk("active ps", 8'h20, jps);
    send(1'b1, {lep_pkg::J_CFG_PGN[12:0], 8'h42, 8'h11}, {32'h5, 8'h00, lep_pkg::J_CFG_KEY});
    repeat (3) @(posedge clk);
    chk("cycle applied", 16'h0005, cyc);
    hw <= 1'b1;
    mag <= 1'b1;
    wait_frm(1'b1, rid, 80, dl, d);
    wait_frm(1'b1, rid, 80, dl, d);
    chk("record fault position", lep_pkg::POS_FAULT, d[15:0]);
    quiet("separate error frame", 40, 1'b0, cid(lep_pkg::ID_EMCY_BASE));
    $display("test done: j1939");
  endtask : t_j1939
  task automatic end_sim();
    $display("counts: compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // Watchdog cuts a hang short
  initial begin
    #400us;
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    {jmode, node_set, claimed, nv_sync, nv_done, mag, elem, hw, dat, sync, rxv, rxe, stall, slow} = '0;
    rst = 1'b1;
    node = 7'h7f;
    jsa = 8'h42;
    nv_ps = 8'h20;
    stat = 8'h5a;
    lim = 8'h3c;
    nv_cyc = 16'h0003;
    pos = 32'h12345678;
    spd = 16'h0abc;
    rxid = '0;
    rxd = '0;
    t_start();
    t_sdo();
    t_save();
    t_emcy();
    t_stop();
    t_sync();
    t_j1939();
    end_sim();
  end
endmodule : encoder_can_process_data_bench

// [test/lep_can_master.sv]
`timescale 1ns/100ps
// ****************************************
// Network master taking frames from the encoder
// ****************************************
module lep_can_master (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, high
  input wire logic stall, // Refuse every frame
  input wire logic slow, // Take at most one frame in three cycles
  input wire logic tx_valid, // Frame offered
  output logic tx_ready, // Frame taken
  input wire logic tx_ext, // Extended identifier
  input wire logic [28:0] tx_id, // Identifier
  input wire logic [3:0] tx_dlc, // Length
  input wire logic [63:0] tx_data, // Bytes, byte 0 low
  output logic got, // Frame received pulse
  output logic [97:0] got_frame // Extended flag, id, length, bytes
);
  logic [1:0] pace;
  // Ready pattern: prompt, slow or stalled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pace <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      tx_ready <= !stall && (!slow || pace == 2'h2);
    end
  end
  // Capture each frame on the edge that takes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got <= 1'b0;
      got_frame <= '0;
    end else begin
      got <= tx_valid && tx_ready;
      got_frame <= {tx_ext, tx_id, tx_dlc, tx_data};
    end
  end
endmodule : lep_can_master
